// [accel_event_top.v]
`timescale 1ns/10ps
`default_nettype none
`include "accel_event_defines.vh"

// Behaviour
// [R01] C7h powers up, all axes, fast rate
// [R02] Rate bit at 20h: 0=100Hz, 1=400Hz
// [R03] High-pass path feeds event one comparison
// [R04] Reference-load read captures present acceleration
// [R05] New reference applies at once, no settling
// [R06] Threshold step equals one 18 mg unit
// [R07] Free-fall: all enabled axes below threshold
// [R08] Drop events shorter than duration count
// [R09] D5h selects latched AND of low conditions
// [R10] Source read clears request, re-arms detection
// [R11] Shared pin is OR of both sources
// [R12] Host reads sample set within period
// [R13] Overrun stays visible in status register
// [R14] Pin A bits 2-0, pin B bits 5-3
// [R15] Code 001 event one, 010 event two
// [R16] Code 011 drives OR of both events
// [R17] Code 100 drives the sample ready flag
// [R18] Ready rises on new set, falls after reads
// [R19] Combine bit: 0 any above, 1 all below
// [R20] Latch bit holds event until source read
// [R21] Polarity bit sets active level of pins
module accel_event_top #(
  parameter RATE_LOW_CYCLES  = `RATE_LOW_CYCLES,
  parameter RATE_HIGH_CYCLES = `RATE_HIGH_CYCLES
) (
  input  wire       CLK,
  input  wire       RESET_N,
  input  wire [7:0] ACC_X,
  input  wire [7:0] ACC_Y,
  input  wire [7:0] ACC_Z,
  input  wire       REG_WR,
  input  wire       REG_RD,
  input  wire [7:0] REG_ADDR,
  input  wire [7:0] REG_WDATA,
  output reg  [7:0] REG_RDATA,
  output reg        REG_RVALID,
  output reg        EVENT_PIN_A,
  output reg        EVENT_PIN_B
);

  localparam integer           LOW_LAST_I  = RATE_LOW_CYCLES - 1;
  localparam integer           HIGH_LAST_I = RATE_HIGH_CYCLES - 1;
  localparam [`RATE_CNT_W-1:0] LOW_LAST    = LOW_LAST_I[`RATE_CNT_W-1:0];
  localparam [`RATE_CNT_W-1:0] HIGH_LAST   = HIGH_LAST_I[`RATE_CNT_W-1:0];

  // ========================================================================
  // Configuration registers
  reg [7:0] power_rate_axis_control_q;
  reg [7:0] filter_control_q;
  reg [7:0] pin_function_control_q;
  reg [7:0] event1_config_q;
  reg [7:0] event1_threshold_q;
  reg [7:0] event1_min_duration_q;
  reg [7:0] event2_config_q;
  reg [7:0] event2_threshold_q;
  reg [7:0] event2_min_duration_q;

  wire wr_hit_ctrl1 = REG_WR && (REG_ADDR == `ADDR_POWER_RATE_AXIS_CONTROL);
  wire rd_ref_load  = REG_RD && (REG_ADDR == `ADDR_FILTER_REFERENCE_LOAD);
  wire rd_src1      = REG_RD && (REG_ADDR == `ADDR_EVENT1_SOURCE);
  wire rd_src2      = REG_RD && (REG_ADDR == `ADDR_EVENT2_SOURCE);
  wire rd_out_x     = REG_RD && (REG_ADDR == `ADDR_OUT_X);
  wire rd_out_y     = REG_RD && (REG_ADDR == `ADDR_OUT_Y);
  wire rd_out_z     = REG_RD && (REG_ADDR == `ADDR_OUT_Z);
  wire [2:0] rd_axis = {rd_out_z, rd_out_y, rd_out_x};

  always @(posedge CLK) begin
    if (!RESET_N) begin
      power_rate_axis_control_q <= `RESET_BYTE; // [R02]
      filter_control_q          <= `RESET_BYTE;
      pin_function_control_q    <= `RESET_BYTE;
      event1_config_q           <= `RESET_BYTE;
      event1_threshold_q        <= `RESET_BYTE;
      event1_min_duration_q     <= `RESET_BYTE;
      event2_config_q           <= `RESET_BYTE;
      event2_threshold_q        <= `RESET_BYTE;
      event2_min_duration_q     <= `RESET_BYTE;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `ADDR_POWER_RATE_AXIS_CONTROL: power_rate_axis_control_q <= REG_WDATA; // [R01]
        `ADDR_FILTER_CONTROL:          filter_control_q          <= REG_WDATA;
        `ADDR_PIN_FUNCTION_CONTROL:    pin_function_control_q    <= REG_WDATA;
        `ADDR_EVENT1_CONFIG:           event1_config_q           <= REG_WDATA;
        `ADDR_EVENT1_THRESHOLD:        event1_threshold_q        <= REG_WDATA;
        `ADDR_EVENT1_MIN_DURATION:     event1_min_duration_q     <= REG_WDATA;
        `ADDR_EVENT2_CONFIG:           event2_config_q           <= REG_WDATA;
        `ADDR_EVENT2_THRESHOLD:        event2_threshold_q        <= REG_WDATA;
        `ADDR_EVENT2_MIN_DURATION:     event2_min_duration_q     <= REG_WDATA;
        default: begin
        end
      endcase
    end
  end

  wire       powered   = power_rate_axis_control_q[`POWER_ON_BIT];
  wire       rate_fast = power_rate_axis_control_q[`RATE_SELECT_BIT];
  wire [2:0] axis_en   = power_rate_axis_control_q[`AXIS_ENABLE_MSB:`AXIS_ENABLE_LSB];

  // ========================================================================
  // Output sample rate divider
  reg  [`RATE_CNT_W-1:0] rate_cnt_q;
  wire [`RATE_CNT_W-1:0] rate_last = rate_fast ? HIGH_LAST : LOW_LAST; // [R02] [R01]
  wire                   sample_en = powered && (rate_cnt_q >= rate_last);
  reg                    eval_en_q;

  always @(posedge CLK) begin
    if (!RESET_N) begin
      rate_cnt_q <= {`RATE_CNT_W{1'b0}};
      eval_en_q  <= 1'b0;
    end else begin
      eval_en_q <= sample_en;
      if (!powered || sample_en || wr_hit_ctrl1) begin
        // A rate change restarts the period so the new rate takes hold at once.
        rate_cnt_q <= {`RATE_CNT_W{1'b0}};
      end else begin
        rate_cnt_q <= rate_cnt_q + {{(`RATE_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ========================================================================
  // Sample capture, ready and overrun tracking
  reg [7:0] out_q [0:2];
  reg [2:0] ready_q;
  reg [2:0] overrun_q;
  wire [7:0] acc_in [0:2];
  integer i;
  integer j;
  integer k;

  assign acc_in[0] = ACC_X;
  assign acc_in[1] = ACC_Y;
  assign acc_in[2] = ACC_Z;

  always @(posedge CLK) begin
    if (!RESET_N) begin
      for (i = 0; i < 3; i = i + 1) begin
        out_q[i] <= 8'h00;
      end
      ready_q   <= 3'h0;
      overrun_q <= 3'h0;
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        if (sample_en && axis_en[i]) begin
          out_q[i]   <= acc_in[i];
          ready_q[i] <= 1'b1; // [R18]
          // A new sample over an unread one is an overrun; a read in the same cycle clears it instead.
          if (ready_q[i] && !rd_axis[i]) begin
            overrun_q[i] <= 1'b1; // [R13] [R12]
          end else if (rd_axis[i]) begin
            overrun_q[i] <= 1'b0;
          end
        end else if (rd_axis[i]) begin
          ready_q[i]   <= 1'b0; // [R18]
          overrun_q[i] <= 1'b0;
        end
      end
    end
  end

  wire sample_ready_flag = |(ready_q & axis_en); // [R18] [R17]
  wire overrun_flag      = |(overrun_q & axis_en); // [R13]
  wire [7:0] status_value = {overrun_flag, overrun_q, sample_ready_flag, ready_q};

  // ========================================================================
  // High-pass reference per axis
  reg  [7:0] ref_q [0:2];
  reg  [8:0] diff  [0:2];
  reg  [7:0] hp    [0:2];
  reg  [8:0] step  [0:2];
  reg  [2:0] shift;

  always @* begin
    shift = `HP_BASE_SHIFT + {1'b0, filter_control_q[`HP_CUTOFF_MSB:`HP_CUTOFF_LSB]};
    for (j = 0; j < 3; j = j + 1) begin
      diff[j] = {out_q[j][7], out_q[j]} - {ref_q[j][7], ref_q[j]};
      step[j] = $signed(diff[j]) >>> shift;
      if (diff[j][8] != diff[j][7]) begin
        hp[j] = diff[j][8] ? 8'h80 : 8'h7f;
      end else begin
        hp[j] = diff[j][7:0];
      end
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      for (k = 0; k < 3; k = k + 1) begin
        ref_q[k] <= 8'h00;
      end
    end else begin
      for (k = 0; k < 3; k = k + 1) begin
        if (rd_ref_load) begin
          ref_q[k] <= out_q[k]; // [R04] [R05]
        end else if (eval_en_q) begin
          // The reference tracks the slow component; its residue is the high band.
          ref_q[k] <= ref_q[k] + step[k][7:0]; // [R03]
        end
      end
    end
  end

  // ========================================================================
  // Event sources
  wire       hp1 = filter_control_q[`HP_EVENT1_BIT];
  wire       hp2 = filter_control_q[`HP_EVENT2_BIT];
  wire       event1_active;
  wire       event2_active;
  wire [7:0] event1_source;
  wire [7:0] event2_source;

  // Threshold and data share one 18 mg unit, so codes compare directly.
  event_detector u_event1 (
    .clk     (CLK),
    .reset_n (RESET_N),
    .eval_en (eval_en_q),
    .axis_x  (hp1 ? hp[0] : out_q[0]), // [R03]
    .axis_y  (hp1 ? hp[1] : out_q[1]),
    .axis_z  (hp1 ? hp[2] : out_q[2]),
    .cfg     (event1_config_q),
    .ths     (event1_threshold_q), // [R06]
    .dur     (event1_min_duration_q), // [R08]
    .src_rd  (rd_src1), // [R10]
    .active  (event1_active),
    .src     (event1_source)
  );

  event_detector u_event2 (
    .clk     (CLK),
    .reset_n (RESET_N),
    .eval_en (eval_en_q),
    .axis_x  (hp2 ? hp[0] : out_q[0]),
    .axis_y  (hp2 ? hp[1] : out_q[1]),
    .axis_z  (hp2 ? hp[2] : out_q[2]),
    .cfg     (event2_config_q),
    .ths     (event2_threshold_q), // [R06]
    .dur     (event2_min_duration_q), // [R08]
    .src_rd  (rd_src2), // [R10]
    .active  (event2_active),
    .src     (event2_source)
  );

  // ========================================================================
  // Pin routing
  wire [2:0] sel_a    = pin_function_control_q[`PIN_A_SEL_MSB:`PIN_A_SEL_LSB]; // [R14]
  wire [2:0] sel_b    = pin_function_control_q[`PIN_B_SEL_MSB:`PIN_B_SEL_LSB]; // [R14]
  wire       polarity = pin_function_control_q[`PIN_POLARITY_BIT];
  reg        level_a;
  reg        level_b;

  always @* begin
    case (sel_a)
      `PIN_SEL_EVENT1:   level_a = event1_active; // [R15]
      `PIN_SEL_EVENT2:   level_a = event2_active; // [R15]
      `PIN_SEL_EVENT_OR: level_a = event1_active | event2_active; // [R16] [R11]
      `PIN_SEL_READY:    level_a = sample_ready_flag; // [R17]
      default:           level_a = 1'b0;
    endcase
    case (sel_b)
      `PIN_SEL_EVENT1:   level_b = event1_active; // [R15]
      `PIN_SEL_EVENT2:   level_b = event2_active; // [R15]
      `PIN_SEL_EVENT_OR: level_b = event1_active | event2_active; // [R16] [R11]
      `PIN_SEL_READY:    level_b = sample_ready_flag; // [R17]
      default:           level_b = 1'b0;
    endcase
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      EVENT_PIN_A <= 1'b0;
      EVENT_PIN_B <= 1'b0;
    end else begin
      EVENT_PIN_A <= level_a ^ polarity; // [R21]
      EVENT_PIN_B <= level_b ^ polarity; // [R21]
    end
  end

  // ========================================================================
  // Register read port
  reg [7:0] rdata_d;

  always @* begin
    case (REG_ADDR)
      `ADDR_POWER_RATE_AXIS_CONTROL: rdata_d = power_rate_axis_control_q;
      `ADDR_FILTER_CONTROL:          rdata_d = filter_control_q;
      `ADDR_PIN_FUNCTION_CONTROL:    rdata_d = pin_function_control_q;
      `ADDR_STATUS:                  rdata_d = status_value; // [R13]
      `ADDR_OUT_X:                   rdata_d = out_q[0];
      `ADDR_OUT_Y:                   rdata_d = out_q[1];
      `ADDR_OUT_Z:                   rdata_d = out_q[2];
      `ADDR_EVENT1_CONFIG:           rdata_d = event1_config_q;
      `ADDR_EVENT1_SOURCE:           rdata_d = event1_source;
      `ADDR_EVENT1_THRESHOLD:        rdata_d = event1_threshold_q;
      `ADDR_EVENT1_MIN_DURATION:     rdata_d = event1_min_duration_q;
      `ADDR_EVENT2_CONFIG:           rdata_d = event2_config_q;
      `ADDR_EVENT2_SOURCE:           rdata_d = event2_source;
      `ADDR_EVENT2_THRESHOLD:        rdata_d = event2_threshold_q;
      `ADDR_EVENT2_MIN_DURATION:     rdata_d = event2_min_duration_q;
      default:                       rdata_d = 8'h00;
    endcase
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_d;
      end
    end
  end

endmodule

`default_nettype wire

// [accel_event_defines.vh]
`ifndef ACCEL_EVENT_DEFINES_VH
`define ACCEL_EVENT_DEFINES_VH

// ==========================================================================
// Register offsets
`define ADDR_POWER_RATE_AXIS_CONTROL 8'h20
`define ADDR_FILTER_CONTROL          8'h21
`define ADDR_PIN_FUNCTION_CONTROL    8'h22
`define ADDR_FILTER_REFERENCE_LOAD   8'h23
`define ADDR_STATUS                  8'h27
`define ADDR_OUT_X                   8'h29
`define ADDR_OUT_Y                   8'h2b
`define ADDR_OUT_Z                   8'h2d
`define ADDR_EVENT1_CONFIG           8'h30
`define ADDR_EVENT1_SOURCE           8'h31
`define ADDR_EVENT1_THRESHOLD        8'h32
`define ADDR_EVENT1_MIN_DURATION     8'h33
`define ADDR_EVENT2_CONFIG           8'h34
`define ADDR_EVENT2_SOURCE           8'h35
`define ADDR_EVENT2_THRESHOLD        8'h36
`define ADDR_EVENT2_MIN_DURATION     8'h37

// ==========================================================================
// Reset values
`define RESET_BYTE                   8'h00

// ==========================================================================
// Field positions
`define RATE_SELECT_BIT              7
`define POWER_ON_BIT                 6
`define AXIS_ENABLE_MSB              2
`define AXIS_ENABLE_LSB              0
`define HP_EVENT1_BIT                2
`define HP_EVENT2_BIT                3
`define HP_CUTOFF_MSB                1
`define HP_CUTOFF_LSB                0
`define PIN_A_SEL_MSB                2
`define PIN_A_SEL_LSB                0
`define PIN_B_SEL_MSB                5
`define PIN_B_SEL_LSB                3
`define PIN_POLARITY_BIT             7
`define COMBINE_SELECT_BIT           7
`define EVENT_LATCH_BIT              6
`define AXIS_COND_MSB                5
`define STATUS_READY_ALL_BIT         3
`define STATUS_OVERRUN_ALL_BIT       7
`define HP_BASE_SHIFT                3'd3

// ==========================================================================
// Pin function codes
`define PIN_SEL_OFF                  3'h0
`define PIN_SEL_EVENT1               3'h1
`define PIN_SEL_EVENT2               3'h2
`define PIN_SEL_EVENT_OR             3'h3
`define PIN_SEL_READY                3'h4

// ==========================================================================
// Timing
`define CLK_HZ                       25000000
`define RATE_LOW_HZ                  100
`define RATE_HIGH_HZ                 400
`define RATE_LOW_CYCLES              (`CLK_HZ / `RATE_LOW_HZ)
`define RATE_HIGH_CYCLES             (`CLK_HZ / `RATE_HIGH_HZ)
`define RATE_CNT_W                   18

`endif

// [event_detector.v]
`timescale 1ns/10ps
`default_nettype none
`include "accel_event_defines.vh"

module event_detector (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       eval_en,
  input  wire [7:0] axis_x,
  input  wire [7:0] axis_y,
  input  wire [7:0] axis_z,
  input  wire [7:0] cfg,
  input  wire [7:0] ths,
  input  wire [7:0] dur,
  input  wire       src_rd,
  output wire       active,
  output wire [7:0] src
);

  // ========================================================================
  // Magnitude compare per axis
  wire [7:0] mag_x = axis_x[7] ? (8'h00 - axis_x) : axis_x;
  wire [7:0] mag_y = axis_y[7] ? (8'h00 - axis_y) : axis_y;
  wire [7:0] mag_z = axis_z[7] ? (8'h00 - axis_z) : axis_z;
  wire [7:0] ths7  = {1'b0, ths[6:0]};
  wire [5:0] cond  = {mag_z > ths7, mag_z < ths7,
                      mag_y > ths7, mag_y < ths7,
                      mag_x > ths7, mag_x < ths7};
  wire [5:0] en    = cfg[`AXIS_COND_MSB:0];
  wire [5:0] seen  = cond & en;
  wire       hit_and = (en != 6'h00) && (&(~en | cond));
  wire       hit_or  = |seen;
  wire       hit     = cfg[`COMBINE_SELECT_BIT] ? hit_and : hit_or; // [R19] [R03] [R07] [R09]
  wire       latch   = cfg[`EVENT_LATCH_BIT];

  reg  [7:0] cnt_q;
  reg  [7:0] cnt_d;
  reg        ia_q;
  reg  [5:0] flags_q;
  wire       qualified = hit && (cnt_d >= dur); // [R08]

  always @* begin
    cnt_d = 8'h00;
    if (hit) begin
      cnt_d = (cnt_q == 8'hff) ? 8'hff : (cnt_q + 8'h01);
    end
  end

  // ========================================================================
  // Duration counter and event flag
  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_q   <= 8'h00;
      ia_q    <= 1'b0;
      flags_q <= 6'h00;
    end else begin
      if (eval_en) begin
        cnt_q <= cnt_d;
      end
      if (latch) begin
        // Set wins over a clearing source read in the same cycle.
        if (eval_en && qualified) begin
          ia_q    <= 1'b1; // [R20] [R09]
          flags_q <= (src_rd ? 6'h00 : flags_q) | seen;
        end else if (src_rd) begin
          ia_q    <= 1'b0; // [R10]
          flags_q <= 6'h00;
        end
      end else if (eval_en) begin
        ia_q    <= qualified; // [R20]
        flags_q <= qualified ? seen : 6'h00;
      end
    end
  end

  assign active = ia_q;
  assign src    = {1'b0, ia_q, flags_q};

endmodule

`default_nettype wire

// [accel_event_top_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Port checker.
module accel_event_checker #(
  parameter RATE_LOW_CYCLES  = 40,
  parameter RATE_HIGH_CYCLES = 10
) (
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_RVALID,
  input wire logic       EVENT_PIN_A,
  input wire logic       EVENT_PIN_B
);
  logic [7:0] ctrl_q;
  logic [7:0] pinfn_q;
  logic       a_off;
  logic       b_off;
  // Shadows of the control bytes predict readback and idle pin levels.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl_q  <= 8'h00;
      pinfn_q <= 8'h00;
    end else if (REG_WR && REG_ADDR == 8'h20) begin
      ctrl_q <= REG_WDATA;
    end else if (REG_WR && REG_ADDR == 8'h22) begin
      pinfn_q <= REG_WDATA;
    end
  end
  assign a_off = (pinfn_q[2:0] == 3'h0) || (pinfn_q[2:0] > 3'h4);
  assign b_off = (pinfn_q[5:3] == 3'h0) || (pinfn_q[5:3] > 3'h4);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_read_answer: assert property (REG_RD |=> REG_RVALID && !$past(REG_WR))
    else $error("read got no answer");
  a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD))
    else $error("answer without read");
  a_rdata_holds: assert property (!REG_RVALID |-> $stable(REG_RDATA))
    else $error("read data moved");
  a_refload_empty: assert property (REG_RD && (REG_ADDR == 8'h23 || REG_ADDR == 8'h00)
    |=> REG_RDATA == 8'h00)
    else $error("reference or unmapped read not zero");
  a_ctrl_readback: assert property (REG_RD && REG_ADDR == 8'h20 |=> REG_RDATA == ctrl_q)
    else $error("rate control readback wrong");
  a_pinfn_readback: assert property (REG_RD && REG_ADDR == 8'h22 |=> REG_RDATA == pinfn_q)
    else $error("pin function readback wrong");
  a_pin_a_idle: assert property ((a_off && $stable(pinfn_q))[*4] |-> EVENT_PIN_A == pinfn_q[7])
    else $error("pin a not idle");
  a_pin_b_idle: assert property ((b_off && $stable(pinfn_q))[*4] |-> EVENT_PIN_B == pinfn_q[7])
    else $error("pin b not idle");
  a_reset_quiet: assert property (disable iff (1'b0)
    !RESET_N |=> !EVENT_PIN_A && !EVENT_PIN_B && !REG_RVALID)
    else $error("outputs active after reset");
endmodule

bind accel_event_top accel_event_checker #(
  .RATE_LOW_CYCLES  (RATE_LOW_CYCLES),
  .RATE_HIGH_CYCLES (RATE_HIGH_CYCLES)
) u_accel_event_checker (
  .CLK(CLK), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .EVENT_PIN_A(EVENT_PIN_A), .EVENT_PIN_B(EVENT_PIN_B)
);
`default_nettype wire

// [accel_sense_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Sensing element: holds each axis until a new set is loaded.
module accel_sense_model (
  input  wire logic       clk,
  input  wire logic       load,
  input  wire logic [7:0] x_in,
  input  wire logic [7:0] y_in,
  input  wire logic [7:0] z_in,
  output logic      [7:0] acc_x,
  output logic      [7:0] acc_y,
  output logic      [7:0] acc_z
);
  initial begin
    acc_x = 8'h00;
    acc_y = 8'h00;
    acc_z = 8'h00;
  end
  always @(posedge clk) begin
    if (load) begin
      acc_x <= x_in;
      acc_y <= y_in;
      acc_z <= z_in;
    end
  end
endmodule
`default_nettype wire

// [test_accel_event_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((ex) !== (got)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_accel_event_top;
  logic       clk, reset_n, reg_wr, reg_rd, load, reg_rvalid, pin_a, pin_b;
  logic [7:0] reg_addr, reg_wdata, x_in, y_in, z_in, acc_x, acc_y, acc_z, reg_rdata;
  logic [7:0] rx, ry, rz, b, e;
  logic [7:0] exp_q[$];
  logic [7:0] ra[7] = '{8'h20, 8'h21, 8'h22, 8'h27, 8'h30, 8'h31, 8'h00};
  int         fails = 0, checks = 0, cyc = 0, t1, t2;
  accel_sense_model u_accel_sense_model (.clk(clk), .load(load), .x_in(x_in), .y_in(y_in),
    .z_in(z_in), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z));
  accel_event_top #(.RATE_LOW_CYCLES(40), .RATE_HIGH_CYCLES(10)) u_accel_event_top (
    .CLK(clk), .RESET_N(reset_n), .ACC_X(acc_x), .ACC_Y(acc_y), .ACC_Z(acc_z),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .EVENT_PIN_A(pin_a), .EVENT_PIN_B(pin_b));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  // ==========================================================================
  // Read monitor: each answer is matched against the oldest expectation.
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      e = exp_q.pop_front();
      `CHK("REG_RDATA", e, reg_rdata)
    end
  end
  task automatic complete_run();
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================================
  // Bus, stimulus and pin tasks.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(ex);
    @(negedge clk);
    reg_rd = 1'b0;
  endtask
  task automatic acc(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    @(negedge clk);
    load = 1'b1;
    x_in = x;
    y_in = y;
    z_in = z;
    @(negedge clk);
    load = 1'b0;
  endtask
  task automatic pins(input logic ea, input logic eb, input int n);
    repeat (n) @(negedge clk);
    `CHK("EVENT_PIN_A", ea, pin_a)
    `CHK("EVENT_PIN_B", eb, pin_b)
  endtask
  task automatic rise(output int t);
    for (int i = 0; i < 100 && pin_a !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 100 && pin_a !== 1'b1; i++) @(negedge clk);
    t = cyc;
  endtask
  // The host finishes the whole set well inside one output period.
  task automatic read_xyz(input bit chk);
    rd(8'h29, rx);
    rd(8'h2b, ry);
    if (chk) pins(1'b1, 1'b0, 0);
    rd(8'h2d, rz);
    if (chk) pins(1'b0, 1'b0, 3);
  endtask
  // ==========================================================================
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    load = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {x_in, y_in, z_in} = 24'h000000;
    void'($urandom(32'hcbe3));
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 7; i++) rd(ra[i], 8'h00);
    wr(8'h27, 8'hff);
    rd(8'h27, 8'h00);
    rx = 8'($urandom());
    ry = 8'($urandom());
    rz = 8'($urandom());
    acc(rx, ry, rz);
    wr(8'h22, 8'h04);
    for (int k = 0; k < 2; k++) begin
      wr(8'h20, k ? 8'hc7 : 8'h47);
      rd(8'h20, k ? 8'hc7 : 8'h47);
      rise(t1);
      read_xyz(k == 0);
      rise(t2);
      `CHK("period", k ? 10 : 40, t2 - t1)
      read_xyz(1'b0);
    end
    repeat (35) @(negedge clk);
    rd(8'h27, 8'hff);
    wr(8'h20, 8'h00);
    repeat (15) @(negedge clk);
    read_xyz(1'b0);
    rd(8'h27, 8'h00);
    wr(8'h22, 8'h80);
    pins(1'b1, 1'b1, 5);
    wr(8'h22, 8'h84);
    pins(1'b1, 1'b1, 5);
    // Wake-up on filtered data against a captured reference.
    b = 8'(30 + $urandom_range(19));
    wr(8'h20, 8'hc7);
    wr(8'h21, 8'h04);
    wr(8'h22, 8'h01);
    wr(8'h32, 8'h0a);
    wr(8'h33, 8'h00);
    acc(b, b, b);
    repeat (25) @(negedge clk);
    rd(8'h23, 8'h00);
    wr(8'h30, 8'h6a);
    pins(1'b0, 1'b0, 30);
    acc(b + 8'h0a, b, b);
    pins(1'b0, 1'b0, 15);
    rd(8'h23, 8'h00);
    acc(b + 8'h15, b, b);
    pins(1'b1, 1'b0, 15);
    rd(8'h23, 8'h00);
    pins(1'b1, 1'b0, 30);
    rd(8'h31, 8'h42);
    pins(1'b0, 1'b0, 5);
    pins(1'b0, 1'b0, 30);
    // Free-fall with minimum duration; the source stays idle until fully set up.
    wr(8'h30, 8'h00);
    wr(8'h21, 8'h00);
    wr(8'h32, 8'h14);
    wr(8'h33, 8'h09);
    wr(8'h22, 8'h19);
    wr(8'h30, 8'hd5);
    acc(8'h13, 8'hed, 8'h00);
    pins(1'b0, 1'b0, 75);
    pins(1'b1, 1'b1, 30);
    wr(8'h22, 8'h12);
    pins(1'b0, 1'b0, 5);
    wr(8'h22, 8'h0a);
    pins(1'b0, 1'b1, 5);
    acc(8'h28, 8'h28, 8'h28);
    pins(1'b0, 1'b1, 15);
    rd(8'h31, 8'h55);
    pins(1'b0, 1'b0, 5);
    complete_run();
  end
endmodule
`default_nettype wire
